// ==== core/psc_pkg.sv ====
// Constants and carriers for the processor status register bank.
// Assumes one core clock; PLL output cycles equal core clock cycles here.
package psc_pkg;

   localparam int PSC_NUM_W = 8;
   localparam int PSC_SLOTS = 50;
   localparam int PSC_RANGES = 13;

   // Register numbers of the dedicated fields
   localparam logic [7:0] PSC_NUM_RAM_BASE = 8'h00;
   localparam logic [7:0] PSC_NUM_VEC_BASE = 8'h01;
   localparam logic [7:0] PSC_NUM_TILE_CTRL = 8'h02;
   localparam logic [7:0] PSC_NUM_BOOT = 8'h03;
   localparam logic [7:0] PSC_NUM_RING0 = 8'h07;
   localparam logic [7:0] PSC_NUM_RING3 = 8'h0a;
   localparam logic [7:0] PSC_NUM_MEM_SIZE = 8'h0c;

   // Reset values, writable masks and the memory size read mask
   localparam logic [31:0] PSC_RAM_RESET = 32'h0004_0000;
   localparam logic [31:0] PSC_RAM_MASK = 32'hffff_fffc;
   localparam logic [31:0] PSC_VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] PSC_VEC_MASK = 32'hfffc_0000;
   localparam logic [31:0] PSC_TILE_RESET = 32'h0000_0000;
   localparam logic [31:0] PSC_TILE_MASK = 32'h03ff_ff36;
   localparam logic [31:0] PSC_MEM_MASK = 32'hffff_fffc;
   localparam logic [31:0] PSC_SEC_MASK = 32'h8000_5fb1;
   localparam logic [31:0] PSC_RING_CTRL_MASK = 32'h0000_0003;
   localparam logic [31:0] PSC_FULL_MASK = 32'hffff_ffff;

   // Tile control field positions and the vector base split
   localparam int PSC_TX_DELAY_HI = 25;
   localparam int PSC_TX_DELAY_LO = 18;
   localparam int PSC_TX_DIV_HI = 17;
   localparam int PSC_TX_DIV_LO = 9;
   localparam int PSC_RGMII_EN_BIT = 8;
   localparam int PSC_DYN_MODE_BIT = 5;
   localparam int PSC_DIV_EN_BIT = 4;
   localparam int PSC_UTMI_SEL_BIT = 2;
   localparam int PSC_ULPI_EN_BIT = 1;
   localparam int PSC_VEC_SPLIT = 16;

   // Core clock divide ratio in low-power mode
   localparam logic [7:0] PSC_CORE_DIV = 8'h04;

   // Storage ranges: first number, last number, first slot, mask
   localparam logic [PSC_RANGES-1:0][7:0] PSC_RNG_LO = {
      8'h06, 8'h05, 8'h9c, 8'h90, 8'h80, 8'h70, 8'h60,
      8'h50, 8'h40, 8'h30, 8'h20, 8'h18, 8'h10};
   localparam logic [PSC_RANGES-1:0][7:0] PSC_RNG_HI = {
      8'h06, 8'h05, 8'h9f, 8'h93, 8'h83, 8'h73, 8'h63,
      8'h53, 8'h43, 8'h33, 8'h27, 8'h18, 8'h16};
   localparam logic [PSC_RANGES-1:0][7:0] PSC_RNG_SLOT = {
      8'h31, 8'h30, 8'h2c, 8'h28, 8'h24, 8'h20, 8'h1c,
      8'h18, 8'h14, 8'h10, 8'h08, 8'h07, 8'h00};
   localparam logic [PSC_RANGES-1:0][31:0] PSC_RNG_MASK = {
      PSC_RING_CTRL_MASK, PSC_SEC_MASK, {11{PSC_FULL_MASK}}};

   // Status read or write request from the core
   typedef struct packed {
      logic valid;
      logic write;
      logic [PSC_NUM_W-1:0] num;
      logic [31:0] wdata;
   } psc_req_t;

   // Answer to a status request
   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } psc_rsp_t;

   // Read-only values supplied by the tile
   typedef struct packed {
      logic [31:0] boot;
      logic [3:0][15:0] ring;
      logic [31:0] mem_size;
   } psc_stat_t;

endpackage : psc_pkg

// ==== core/psc_regs.sv ====
// Processor status register bank with tile control side effects.
// Assumes requests are synchronous to clk and PLL output equals clk.
module psc_regs
   import psc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Status access port
   input wire psc_req_t req,
   output psc_rsp_t rsp,
   // Tile status inputs
   input wire psc_stat_t stat,
   input wire logic all_paused,
   // Event vectoring
   input wire logic event_take,
   input wire logic [15:0] event_vector,
   output logic [31:0] event_target,
   // Configuration outputs
   output logic [31:0] ram_base_addr,
   output logic [31:0] vector_base_addr,
   output logic rgmii_enable,
   output logic rgmii_tx_clk,
   output logic rgmii_tx_strobe,
   output logic core_div_active,
   output logic core_clk_en,
   output logic usb_utmi_sel,
   output logic ulpi_enable
);

   // Whole module state
   typedef struct packed {
      logic [31:0] ram_base;
      logic [31:0] vec_base;
      logic [31:0] tile;
      logic [PSC_SLOTS-1:0][31:0] bank;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic [31:0] target;
      logic [8:0] tx_cnt;
      logic tx_clk;
      logic [7:0] dly_cnt;
      logic tx_strobe;
      logic [7:0] core_cnt;
      logic core_en;
   } psc_state_t;

   psc_state_t st;
   psc_state_t next_st;

   // Decode of the request number into a storage slot
   logic hit;
   logic [5:0] slot;
   logic [31:0] slot_mask;
   logic [7:0] diff;

   // Tile control fields
   logic [7:0] tx_delay;
   logic [8:0] tx_div;
   logic tx_rise;
   logic div_on;

   assign tx_delay = st.tile[PSC_TX_DELAY_HI:PSC_TX_DELAY_LO];
   assign tx_div = st.tile[PSC_TX_DIV_HI:PSC_TX_DIV_LO];
   assign tx_rise = rgmii_enable && (st.tx_cnt == tx_div);

   // Range table walk; the debug banks are plain storage
   always_comb begin
      hit = 1'b0;
      slot = 6'h00;
      slot_mask = 32'h0;
      diff = 8'h00;
      for (int i = 0; i < PSC_RANGES; i++) begin
         if (req.num >= PSC_RNG_LO[i] && req.num <= PSC_RNG_HI[i]) begin
            hit = 1'b1;
            diff = 8'(req.num - PSC_RNG_LO[i] + PSC_RNG_SLOT[i]);
            slot = diff[5:0];
            slot_mask = PSC_RNG_MASK[i];
         end
      end
   end

   // Divider applies always in static mode, on pause in dynamic mode
   assign div_on = st.tile[PSC_DIV_EN_BIT]
      && (!st.tile[PSC_DYN_MODE_BIT] || all_paused);

   // Next state
   always_comb begin
      next_st = st;
      next_st.ack = 1'b0;
      next_st.err = 1'b0;
      next_st.tx_strobe = 1'b0;
      // One word per request, answered on the following edge
      if (req.valid) begin
         next_st.ack = 1'b1;
         next_st.rdata = 32'h0;
         if (req.write) begin
            if (req.num == PSC_NUM_RAM_BASE) begin
               next_st.ram_base = req.wdata & PSC_RAM_MASK;
            end else if (req.num == PSC_NUM_VEC_BASE) begin
               next_st.vec_base = req.wdata & PSC_VEC_MASK;
            end else if (req.num == PSC_NUM_TILE_CTRL) begin
               next_st.tile = req.wdata & PSC_TILE_MASK;
            end else if (hit) begin
               next_st.bank[slot] = req.wdata & slot_mask;
            end else begin
               // Read-only or unmapped numbers refuse the write
               next_st.err = 1'b1;
            end
         end else begin
            if (req.num == PSC_NUM_RAM_BASE) begin
               next_st.rdata = st.ram_base;
            end else if (req.num == PSC_NUM_VEC_BASE) begin
               next_st.rdata = st.vec_base;
            end else if (req.num == PSC_NUM_TILE_CTRL) begin
               next_st.rdata = st.tile;
            end else if (req.num == PSC_NUM_BOOT) begin
               next_st.rdata = stat.boot;
            end else if (req.num >= PSC_NUM_RING0
                         && req.num <= PSC_NUM_RING3) begin
               // Ring counts only carry 16 bits
               next_st.rdata = {16'h0,
                  stat.ring[2'(req.num - PSC_NUM_RING0)]};
            end else if (req.num == PSC_NUM_MEM_SIZE) begin
               next_st.rdata = stat.mem_size & PSC_MEM_MASK;
            end else if (hit) begin
               next_st.rdata = st.bank[slot];
            end else begin
               next_st.err = 1'b1;
            end
         end
      end

      // Event target latched when the event is taken
      if (event_take) begin
         next_st.target = {st.vec_base[31:PSC_VEC_SPLIT],
                           event_vector};
      end

      // Transmit clock counter, parked while the ports are off
      if (!rgmii_enable) begin
         next_st.tx_cnt = 9'h000;
         next_st.tx_clk = 1'b0;
      end else if (tx_rise) begin
         next_st.tx_cnt = 9'h000;
         next_st.tx_clk = 1'b1;
      end else begin
         next_st.tx_cnt = 9'(st.tx_cnt + 9'h001);
         if (st.tx_cnt == (tx_div >> 1)) begin
            next_st.tx_clk = 1'b0;
         end
      end

      // Data strobe trails the clock rise by the programmed delay
      if (tx_rise) begin
         next_st.dly_cnt = tx_delay;
         next_st.tx_strobe = (tx_delay == 8'h00);
      end else if (st.dly_cnt != 8'h00) begin
         next_st.dly_cnt = 8'(st.dly_cnt - 8'h01);
         next_st.tx_strobe = (st.dly_cnt == 8'h01);
      end
      if (!rgmii_enable) begin
         next_st.dly_cnt = 8'h00;
         next_st.tx_strobe = 1'b0; // No stray strobe once the ports are off
      end

      // Core clock enable: every cycle, or one in PSC_CORE_DIV
      if (!div_on) begin
         next_st.core_cnt = 8'h00;
         next_st.core_en = 1'b1;
      end else if (st.core_cnt >= PSC_CORE_DIV - 8'h01) begin
         next_st.core_cnt = 8'h00;
         next_st.core_en = 1'b1;
      end else begin
         next_st.core_cnt = 8'(st.core_cnt + 8'h01);
         next_st.core_en = 1'b0;
      end
   end

   // State register; storage banks clear at reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.ram_base <= PSC_RAM_RESET;
         st.vec_base <= PSC_VEC_RESET;
         st.tile <= PSC_TILE_RESET;
         st.core_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state, except core_div_active which also follows all_paused
   assign rsp = '{ack: st.ack, err: st.err, rdata: st.rdata};
   assign event_target = st.target;
   assign ram_base_addr = st.ram_base;
   assign vector_base_addr = st.vec_base;
   assign rgmii_enable = st.tile[PSC_RGMII_EN_BIT];
   assign rgmii_tx_clk = st.tx_clk;
   assign rgmii_tx_strobe = st.tx_strobe;
   assign core_div_active = div_on;
   assign core_clk_en = st.core_en;
   assign usb_utmi_sel = st.tile[PSC_UTMI_SEL_BIT];
   assign ulpi_enable = st.tile[PSC_ULPI_EN_BIT];

   // Checks on the bank's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_ack_next: assert property (
      req.valid |=> rsp.ack ##1 !rsp.ack || $past(req.valid))
      else $error("status request not answered next cycle");

   chk_ram_write: assert property (
      req.valid && req.write && req.num == PSC_NUM_RAM_BASE
      |=> ram_base_addr == ($past(req.wdata) & PSC_RAM_MASK))
      else $error("RAM base write lost or reserved bits kept");

   chk_ram_rsvd: assert property (
      ram_base_addr[1:0] == 2'b00)
      else $error("RAM base reserved bits not zero");

   chk_vec_rsvd: assert property (
      vector_base_addr[17:0] == 18'h0)
      else $error("vector base reserved bits not zero");

   chk_event_target: assert property (
      event_take |=> event_target == {$past(vector_base_addr[31:16]),
                                      $past(event_vector)})
      else $error("event target formed wrongly");

   chk_txclk_rise: assert property (
      tx_rise |=> rgmii_tx_clk)
      else $error("transmit clock did not rise at divider value");

   chk_txclk_fall: assert property (
      rgmii_enable && !tx_rise && st.tx_cnt == (tx_div >> 1)
      |=> !rgmii_tx_clk)
      else $error("transmit clock did not fall at half value");

   chk_strobe_delay: assert property (
      tx_rise && tx_delay == 8'h02 && tx_div >= 9'h002
      ##1 rgmii_enable [*3] |-> rgmii_tx_strobe)
      else $error("data strobe not delayed by programmed count");

   chk_div_static: assert property (
      st.tile[PSC_DIV_EN_BIT] && !st.tile[PSC_DYN_MODE_BIT]
      |-> core_div_active)
      else $error("static divider not applied");

   chk_div_dynamic: assert property (
      st.tile[PSC_DYN_MODE_BIT] && !all_paused |-> !core_div_active)
      else $error("dynamic divider applied while threads run");

   chk_div_rate: assert property (
      core_div_active [*4] |-> $past(core_clk_en) == 1'b0
      || $past(core_clk_en, 2) == 1'b0)
      else $error("core clock enable not divided");

   chk_tile_read: assert property (
      req.valid && !req.write && req.num == PSC_NUM_TILE_CTRL
      |=> (rsp.rdata & ~PSC_TILE_MASK) == 32'h0)
      else $error("tile control reserved bits read nonzero");

   chk_ack_idle: assert property (
      !req.valid |=> !rsp.ack)
      else $error("answer given without a request");

   chk_err_ack: assert property (
      rsp.err |-> rsp.ack)
      else $error("error flag raised without an answer");

   chk_err_rdata: assert property (
      rsp.err |-> rsp.rdata == 32'h0)
      else $error("refused request returned nonzero data");

   chk_rdata_hold: assert property (
      !req.valid |=> $stable(rsp.rdata))
      else $error("read data changed without a request");

   chk_unmapped_err: assert property (
      req.valid && (req.num == 8'h04 || req.num >= 8'ha0)
      |=> rsp.err)
      else $error("unmapped number not refused");

   chk_ro_write: assert property (
      req.valid && req.write && req.num == PSC_NUM_BOOT
      |=> rsp.err)
      else $error("write to boot status not refused");

   chk_ram_hold: assert property (
      !(req.valid && req.write && req.num == PSC_NUM_RAM_BASE)
      |=> $stable(ram_base_addr))
      else $error("RAM base changed without a write");

   chk_vec_write: assert property (
      req.valid && req.write && req.num == PSC_NUM_VEC_BASE
      |=> vector_base_addr == ($past(req.wdata) & PSC_VEC_MASK))
      else $error("vector base write lost or reserved bits kept");

   chk_vec_hold: assert property (
      !(req.valid && req.write && req.num == PSC_NUM_VEC_BASE)
      |=> $stable(vector_base_addr))
      else $error("vector base changed without a write");

   chk_event_hold: assert property (
      !event_take |=> $stable(event_target))
      else $error("event target changed without an event");

   chk_rgmii_write: assert property (
      req.valid && req.write && req.num == PSC_NUM_TILE_CTRL
      |=> rgmii_enable == $past(req.wdata[PSC_RGMII_EN_BIT]))
      else $error("port enable bit not taken from write");

   chk_utmi_write: assert property (
      req.valid && req.write && req.num == PSC_NUM_TILE_CTRL
      |=> usb_utmi_sel == $past(req.wdata[PSC_UTMI_SEL_BIT]))
      else $error("transceiver select not taken from write");

   chk_ulpi_write: assert property (
      req.valid && req.write && req.num == PSC_NUM_TILE_CTRL
      |=> ulpi_enable == $past(req.wdata[PSC_ULPI_EN_BIT]))
      else $error("support module enable not taken from write");

   chk_tile_hold: assert property (
      !(req.valid && req.write && req.num == PSC_NUM_TILE_CTRL)
      |=> $stable(st.tile))
      else $error("tile control changed without a write");

   chk_txclk_park: assert property (
      !rgmii_enable |=> !rgmii_tx_clk)
      else $error("transmit clock runs while ports are off");

   chk_strobe_park: assert property (
      !rgmii_enable |=> !rgmii_tx_strobe)
      else $error("data strobe while ports are off");

   chk_core_full: assert property (
      !core_div_active |=> core_clk_en)
      else $error("core clock gated while divider is off");

   chk_core_gap: assert property (
      core_div_active && core_clk_en |=> !core_clk_en)
      else $error("core clock enable high twice in a row");

   chk_ring_read: assert property (
      req.valid && !req.write && req.num >= PSC_NUM_RING0
      && req.num <= PSC_NUM_RING3 |=> rsp.rdata[31:16] == 16'h0)
      else $error("ring count upper half not zero");

   chk_mem_read: assert property (
      req.valid && !req.write && req.num == PSC_NUM_MEM_SIZE
      |=> rsp.rdata[1:0] == 2'b00)
      else $error("memory size reserved bits not zero");

   chk_ram_read: assert property (
      req.valid && !req.write && req.num == PSC_NUM_RAM_BASE
      |=> rsp.rdata == $past(ram_base_addr))
      else $error("RAM base read returned wrong word");

   chk_strobe_zero: assert property (
      tx_rise && tx_delay == 8'h00 |=> rgmii_tx_strobe)
      else $error("zero delay strobe not with clock rise");

endmodule : psc_regs

// ==== verification/psc_core_model.sv ====
// Model of the local core issuing status reads and writes.
// Assumes the bank answers one cycle after the edge that takes a request.
module psc_core_model
   import psc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Status access port
   output psc_req_t req,
   input wire psc_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req = '0;

   // Resource id: register number above the status resource type
   function automatic logic [15:0] res_id(input logic [7:0] num);
      return {num, 8'h0b};
   endfunction : res_id

   // One word per request; qualifiers scrambled once released
   task automatic access(input logic wr, input logic [7:0] num,
         input logic [31:0] wdata, output logic [31:0] rdata,
         output logic err, output logic ack);
      logic [15:0] id;
      id = res_id(num);
      @(posedge clk);
      req <= '{valid: 1'b1, write: wr, num: id[15:8], wdata: wdata};
      @(posedge clk);
      req <= '{valid: 1'b0, write: ~wr, num: ~num, wdata: ~wdata};
      @(posedge clk);
      rdata = rsp.rdata;
      err = rsp.err;
      ack = rsp.ack;
   endtask : access
endmodule : psc_core_model

// ==== verification/psc_regs_tb_top.sv ====
// Bench for the status register bank: map, tile control side effects.
// Assumes the core model owns the request port.
module psc_regs_tb_top
   import psc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic all_paused = 1'b0;
   logic event_take = 1'b0;
   logic [15:0] event_vector = 16'h0000;
   psc_stat_t stat = '{32'h1234_5678,
      {16'h4444, 16'h3333, 16'h2222, 16'h1111}, 32'h0008_0003};
   psc_req_t req;
   psc_rsp_t rsp;
   logic [31:0] event_target, ram_base_addr, vector_base_addr;
   logic rgmii_enable, rgmii_tx_clk, rgmii_tx_strobe, core_div_active;
   logic core_clk_en, usb_utmi_sel, ulpi_enable;
   logic [31:0] rd_data, cnt;
   logic rd_err;
   logic rd_ack;
   logic [15:0] cs, ss;
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   int r0, r1, st;

   always #10 clk = ~clk;

   psc_regs DUT (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
      .stat(stat), .all_paused(all_paused), .event_take(event_take),
      .event_vector(event_vector), .event_target(event_target),
      .ram_base_addr(ram_base_addr), .vector_base_addr(vector_base_addr),
      .rgmii_enable(rgmii_enable), .rgmii_tx_clk(rgmii_tx_clk),
      .rgmii_tx_strobe(rgmii_tx_strobe), .core_div_active(core_div_active),
      .core_clk_en(core_clk_en), .usb_utmi_sel(usb_utmi_sel),
      .ulpi_enable(ulpi_enable));

   psc_core_model core (.clk(clk), .req(req), .rsp(rsp));

   task summarize;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Bus cycles through the core model, error flag always compared
   task wr(input logic [7:0] n, input logic [31:0] d, input logic e);
      core.access(1'b1, n, d, rd_data, rd_err, rd_ack);
      check({31'h0, rd_ack}, 32'h1);
      check({31'h0, rd_err}, {31'h0, e});
      check(rd_data, 32'h0);
   endtask : wr

   task rd(input logic [7:0] n, input logic [31:0] x, input logic e);
      core.access(1'b0, n, 32'h0, rd_data, rd_err, rd_ack);
      check({31'h0, rd_ack}, 32'h1);
      check({31'h0, rd_err}, {31'h0, e});
      check(rd_data, x);
   endtask : rd

   // Hang guard, well above the under two hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h0004_0000, 1'b0);
      rd(8'h01, 32'h0, 1'b0);
      rd(8'h02, 32'h0, 1'b0);
      wr(8'h00, 32'hffff_ffff, 1'b0);
      rd(8'h00, 32'hffff_fffc, 1'b0);
      check(ram_base_addr, 32'hffff_fffc);
      wr(8'h01, 32'hffff_ffff, 1'b0);
      rd(8'h01, 32'hfffc_0000, 1'b0);
      check(vector_base_addr, 32'hfffc_0000);
      @(posedge clk);
      event_take <= 1'b1;
      event_vector <= 16'h1234;
      @(posedge clk);
      event_take <= 1'b0;
      @(posedge clk);
      check(event_target, 32'hfffc_1234);
      wr(8'h02, 32'hffff_ffff, 1'b0);
      rd(8'h02, 32'h03ff_ff36, 1'b0);
      check({29'h0, rgmii_enable, usb_utmi_sel, ulpi_enable}, 32'h7);
      // Static divider, ULPI mode with support enabled
      wr(8'h02, 32'h0000_0012, 1'b0);
      check({30'h0, usb_utmi_sel, ulpi_enable}, 32'h1);
      check({31'h0, core_div_active}, 32'h1);
      cnt = 32'h0;
      repeat (8) begin
         @(posedge clk);
         cnt = cnt + core_clk_en;
      end
      check(cnt, 32'h2);
      wr(8'h02, 32'h0000_0030, 1'b0);
      check({31'h0, core_div_active}, 32'h0);
      all_paused <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      check({31'h0, core_div_active}, 32'h1);
      // Divide by four programmed as three, data delay of two
      wr(8'h02, 32'h0008_0700, 1'b0);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         cs[i] = rgmii_tx_clk;
         ss[i] = rgmii_tx_strobe;
      end
      r0 = -1;
      r1 = -1;
      st = -1;
      for (int i = 1; i < 16; i++) begin
         if (cs[i] && !cs[i-1]) begin
            if (r0 < 0) r0 = i;
            else if (r1 < 0) r1 = i;
         end
         if (ss[i] && r0 >= 0 && st < 0) st = i;
      end
      check(32'(r1 - r0), 32'd4);
      check(32'(st - r0), 32'd2);
      cnt = 32'h0;
      for (int i = 0; i < 4; i++) cnt = cnt + cs[r0 + i];
      check(cnt, 32'h2);
      wr(8'h02, 32'h0, 1'b0);
      repeat (3) @(posedge clk);
      check({30'h0, rgmii_enable, rgmii_tx_clk}, 32'h0);
      // Watch and break control blocks, written then read back
      for (int i = 0; i < 4; i++) begin
         wr(8'(8'h70 + i), 32'ha5a5_0000 + i, 1'b0);
         wr(8'(8'h9c + i), 32'h5a5a_0000 + i, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         rd(8'(8'h70 + i), 32'ha5a5_0000 + i, 1'b0);
         rd(8'(8'h9c + i), 32'h5a5a_0000 + i, 1'b0);
      end
      // Unmapped numbers and read-only places
      rd(8'h74, 32'h0, 1'b1);
      rd(8'h04, 32'h0, 1'b1);
      rd(8'h9b, 32'h0, 1'b1);
      wr(8'h03, 32'hffff_ffff, 1'b1);
      rd(8'h03, 32'h1234_5678, 1'b0);
      rd(8'h07, 32'h0000_1111, 1'b0);
      // Storage masks of the plain registers, read mask of the memory size
      wr(8'h05, 32'hffff_ffff, 1'b0);
      rd(8'h05, 32'h8000_5fb1, 1'b0);
      wr(8'h06, 32'hffff_ffff, 1'b0);
      rd(8'h06, 32'h0000_0003, 1'b0);
      rd(8'h0c, 32'h0008_0000, 1'b0);
      // Second reset in mid-run restores every register
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h0004_0000, 1'b0);
      rd(8'h02, 32'h0, 1'b0);
      rd(8'h70, 32'h0, 1'b0);
      check(ram_base_addr, 32'h0004_0000);
      summarize();
   end
endmodule : psc_regs_tb_top
